// file: core/signal_router_pkg.sv
// constants for the peripheral signal router and its register map
package signal_router_pkg;
  // register map (byte addresses)
  localparam logic [7:0] OPTIONS_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR  = 8'h04;
  // field positions in system_options_reg
  localparam int TRIG_SEL_LSB   = 0;
  localparam int TRIG_SEL_W     = 2;
  localparam int CMP_CAP_BIT    = 2;
  localparam int TX_MOD_BIT     = 3;
  localparam int RX_CAP_BIT     = 4;
  localparam int RX_FILT_BIT    = 5;
  localparam int CNT_CAP_BIT    = 6;
  localparam int SYNC_BIT       = 7;
  localparam int DELAY_LSB      = 8;
  localparam int DELAY_W        = 8;
  localparam int BUS_REFERENCE_DIVIDER_LSB     = 16;
  localparam int BUS_REFERENCE_DIVIDER_W       = 3;
  localparam int OPT_W          = 19;
  // reset value of the options register
  localparam logic [OPT_W-1:0] OPT_RESET = 19'h00000;
  // trigger source encodings
  typedef enum logic [1:0] {
    TRIG_COUNTER_OVF = 2'h0,
    TRIG_PERIODIC    = 2'h1,
    TRIG_TIMER_INIT  = 2'h2,
    TRIG_TIMER_MATCH = 2'h3
  } trig_sel_e;
  // ahb transfer type, transfer size and response encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;
endpackage

// file: core/trigger_delay.sv
// delay counter between a timer trigger and the converter trigger
`timescale 1ns/1ps
module trigger_delay #(
  parameter int CNT_W = 8,
  parameter int DIV_W = 3
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  // control
  input  wire logic             i_enable,
  input  wire logic [CNT_W-1:0] i_delay,
  input  wire logic [DIV_W-1:0] i_divider,
  input  wire logic             i_trigger,
  // result
  output logic                  o_trigger,
  output logic                  o_busy
);
  localparam int PRE_W = (1 << DIV_W);

  logic [PRE_W-1:0] prescale;
  logic [PRE_W-1:0] next_prescale;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             busy;
  logic             next_busy;
  logic             fire;
  logic             next_fire;
  logic             tick;

  // predivider: tick every 2^divider bus clocks; divider 0 ticks every clock
  always_comb begin
    next_prescale = prescale + {{(PRE_W-1){1'b0}}, 1'b1};
    tick = ((prescale & ((PRE_W'(1) << i_divider) - PRE_W'(1))) == '0);
    next_busy = busy;
    next_count = count;
    next_fire = 1'b0;
    if (!i_enable) begin
      next_busy = 1'b0;
    end else if (i_trigger) begin
      // a new trigger restarts the delay; a pending one is dropped
      next_count = i_delay;
      next_busy = 1'b1;
      next_prescale = '0;
    end else if (busy && tick) begin
      if (count == '0) begin
        next_fire = 1'b1;
        next_busy = 1'b0;
      end else begin
        next_count = count - CNT_W'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      prescale <= '0;
      count <= '0;
      busy <= 1'b0;
      fire <= 1'b0;
    end else begin
      prescale <= next_prescale;
      count <= next_count;
      busy <= next_busy;
      fire <= next_fire;
    end
  end

  assign o_trigger = fire;
  assign o_busy = busy;

  // a trigger with zero delay fires within two cycles when undivided
  sequence zero_start_s;
    i_enable && i_trigger && i_delay == '0 && i_divider == '0;
  endsequence
  zero_delay_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    zero_start_s ##1 (i_enable && !i_trigger) |=> fire)
    else $error("zero delay trigger did not fire");
  pulse_single_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    fire |=> !fire)
    else $error("delayed trigger longer than one cycle");
  disabled_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !i_enable |=> !busy && !fire)
    else $error("delay counter active while disabled");
endmodule

// file: core/peripheral_signal_router.sv
// peripheral signal router: option register on ahb-lite and routing muxes
`timescale 1ns/1ps
// Behaviour
// - select 10 and 11 pick timer two init and match, both delayed
// - timer two triggers pass an 8-bit delay counter set by delay field
// - delay counter ticks on bus clock after selectable predivider
// - comparator capture route feeds comparator to timer one channel zero
// - transmit modulation ANDs serial transmit with timer zero channel zero
// - modulation clear: serial transmit goes straight to its pin
// - receive capture feeds receive pin to serial port and timer zero chan one
// - receive filter feeds serial receive input from comparator zero
// - receive filter active frees the receive pin regardless of remapping
// - filter and capture together send comparator to timer zero channel one
// - counter capture route sends counter overflow to timer one channel one
// - writing 1 to soft sync bit pulses timer two sync trigger
// - writing 0 to soft sync does nothing; bit reads as 0
module peripheral_signal_router #(
  parameter int DELAY_W  = signal_router_pkg::DELAY_W,
  parameter int BUS_REFERENCE_DIVIDER_W = signal_router_pkg::BUS_REFERENCE_DIVIDER_W
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // trigger sources
  input  wire logic        i_counter_ovf,
  input  wire logic        i_periodic_timer_flag,
  input  wire logic        i_timer_init_trigger,
  input  wire logic        i_timer_match_trigger,
  // signal sources
  input  wire logic        i_comparator_zero_out,
  input  wire logic        i_timer_zero_chan_zero_out,
  input  wire logic        i_serial_zero_transmit,
  input  wire logic        i_serial_zero_receive_pin,
  input  wire logic        i_timer_zero_chan_one_pin,
  input  wire logic        i_timer_one_chan_zero_pin,
  input  wire logic        i_timer_one_chan_one_pin,
  // routed outputs
  output logic             o_conv_trigger,
  output logic             o_serial_zero_transmit_pin,
  output logic             o_serial_zero_receive,
  output logic             o_timer_zero_chan_one_in,
  output logic             o_timer_one_chan_zero_in,
  output logic             o_timer_one_chan_one_in,
  output logic             o_soft_sync_trigger,
  // pin release flags, high when the pin is free for another function
  output logic             o_timer_zero_chan_zero_pin_free,
  output logic             o_timer_zero_chan_one_pin_free,
  output logic             o_timer_one_chan_zero_pin_free,
  output logic             o_timer_one_chan_one_pin_free,
  output logic             o_serial_zero_receive_pin_free
);
  // synchronised pin inputs: pin, stage one, stage two
  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  assign pin_raw = {i_timer_one_chan_one_pin, i_timer_one_chan_zero_pin,
                    i_timer_zero_chan_one_pin, i_serial_zero_receive_pin,
                    i_comparator_zero_out};
  logic comp_s;
  logic rx_pin_s;
  logic t0c1_pin_s;
  logic t1c0_pin_s;
  logic t1c1_pin_s;
  assign comp_s = pin_sync[0];
  assign rx_pin_s = pin_sync[1];
  assign t0c1_pin_s = pin_sync[2];
  assign t1c0_pin_s = pin_sync[3];
  assign t1c1_pin_s = pin_sync[4];

  // two flip-flop synchroniser for every pin-side input
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  // bus address phase capture
  logic                               wr_pend;
  logic                               next_wr_pend;
  logic [7:0]                         addr_q;
  logic [7:0]                         next_addr_q;
  logic [signal_router_pkg::OPT_W-1:0] system_options_reg;
  logic [signal_router_pkg::OPT_W-1:0] next_options;
  logic [31:0]                        next_hrdata;
  logic                               sync_pulse;
  logic                               next_sync_pulse;
  logic                               delay_busy;
  logic                               delay_fire;
  logic                               accept;

  // a word at a known address; others answer okay and read zero
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_a);
    addr_hit = (a == reg_a);
  endfunction

  assign accept = i_hsel && i_hready && (i_htrans == signal_router_pkg::HTRANS_NONSEQ);

  // register file next state; slave is zero wait state
  always_comb begin
    next_wr_pend = accept && i_hwrite;
    next_addr_q = accept ? i_haddr : addr_q;
    next_options = system_options_reg;
    next_sync_pulse = 1'b0;
    next_hrdata = 32'h00000000;
    if (wr_pend && addr_hit(addr_q, signal_router_pkg::OPTIONS_ADDR)) begin
      next_options = i_hwdata[signal_router_pkg::OPT_W-1:0];
      // sync bit is a strobe only, never stored
      next_options[signal_router_pkg::SYNC_BIT] = 1'b0;
      next_sync_pulse = i_hwdata[signal_router_pkg::SYNC_BIT];
    end
    if (accept && !i_hwrite) begin
      if (addr_hit(i_haddr, signal_router_pkg::OPTIONS_ADDR)) begin
        // reads see the stored copy, sync bit always zero
        next_hrdata[signal_router_pkg::OPT_W-1:0] = system_options_reg;
      end else if (addr_hit(i_haddr, signal_router_pkg::STATUS_ADDR)) begin
        next_hrdata[1:0] = {delay_fire, delay_busy};
      end
    end
  end

  // register file state
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_pend <= 1'b0;
      addr_q <= 8'h00;
      system_options_reg <= signal_router_pkg::OPT_RESET;
      sync_pulse <= 1'b0;
      o_hrdata <= 32'h00000000;
      // bus answer ties are flops too, so every output is registered
      o_hreadyout <= 1'b1;
      o_hresp <= signal_router_pkg::HRESP_OKAY;
    end else begin
      wr_pend <= next_wr_pend;
      addr_q <= next_addr_q;
      system_options_reg <= next_options;
      sync_pulse <= next_sync_pulse;
      o_hrdata <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp <= signal_router_pkg::HRESP_OKAY;
    end
  end

  // option fields
  logic [1:0]          conv_trigger_select;
  logic                comparator_capture_route;
  logic                transmit_modulation_en;
  logic                receive_capture_en;
  logic                receive_filter_en;
  logic                counter_capture_route;
  logic [DELAY_W-1:0]  delay_value;
  logic [BUS_REFERENCE_DIVIDER_W-1:0] bus_reference_divider;
  assign conv_trigger_select = system_options_reg[signal_router_pkg::TRIG_SEL_LSB +:
                                                  signal_router_pkg::TRIG_SEL_W];
  assign comparator_capture_route = system_options_reg[signal_router_pkg::CMP_CAP_BIT];
  assign transmit_modulation_en = system_options_reg[signal_router_pkg::TX_MOD_BIT];
  assign receive_capture_en = system_options_reg[signal_router_pkg::RX_CAP_BIT];
  assign receive_filter_en = system_options_reg[signal_router_pkg::RX_FILT_BIT];
  assign counter_capture_route = system_options_reg[signal_router_pkg::CNT_CAP_BIT];
  assign delay_value = system_options_reg[signal_router_pkg::DELAY_LSB +: DELAY_W];
  assign bus_reference_divider = system_options_reg[signal_router_pkg::BUS_REFERENCE_DIVIDER_LSB +: BUS_REFERENCE_DIVIDER_W];

  // timer two trigger to the delay block
  logic delay_en;
  logic timer_trig;
  assign delay_en = conv_trigger_select[1];
  assign timer_trig = (conv_trigger_select == signal_router_pkg::TRIG_TIMER_MATCH) ?
                      i_timer_match_trigger : i_timer_init_trigger;

  trigger_delay #(
    .CNT_W (DELAY_W),
    .DIV_W (BUS_REFERENCE_DIVIDER_W)
  ) u_delay (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_enable  (delay_en),
    .i_delay   (delay_value),
    .i_divider (bus_reference_divider),
    .i_trigger (timer_trig),
    .o_trigger (delay_fire),
    .o_busy    (delay_busy)
  );

  // routed signals, combinational mux then one output flop
  logic next_conv;
  logic next_tx;
  logic next_rx;
  logic next_t0c1;
  logic next_t1c0;
  logic next_t1c1;
  always_comb begin
    case (conv_trigger_select)
      signal_router_pkg::TRIG_COUNTER_OVF: next_conv = i_counter_ovf;
      signal_router_pkg::TRIG_PERIODIC:    next_conv = i_periodic_timer_flag;
      signal_router_pkg::TRIG_TIMER_INIT:  next_conv = delay_fire;
      signal_router_pkg::TRIG_TIMER_MATCH: next_conv = delay_fire;
      default:                             next_conv = 1'b0;
    endcase
    // modulation gates transmit with the timer waveform
    next_tx = transmit_modulation_en ? (i_serial_zero_transmit & i_timer_zero_chan_zero_out)
                                     : i_serial_zero_transmit;
    next_rx = receive_filter_en ? comp_s : rx_pin_s;
    // with capture on, the timer sees whatever the serial port receives
    next_t0c1 = receive_capture_en ? next_rx : t0c1_pin_s;
    next_t1c0 = comparator_capture_route ? comp_s : t1c0_pin_s;
    next_t1c1 = counter_capture_route ? i_counter_ovf : t1c1_pin_s;
  end

  // output flops so every output is registered
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_conv_trigger <= 1'b0;
      o_serial_zero_transmit_pin <= 1'b1;
      o_serial_zero_receive <= 1'b1;
      o_timer_zero_chan_one_in <= 1'b0;
      o_timer_one_chan_zero_in <= 1'b0;
      o_timer_one_chan_one_in <= 1'b0;
      o_soft_sync_trigger <= 1'b0;
      o_timer_zero_chan_zero_pin_free <= 1'b0;
      o_timer_zero_chan_one_pin_free <= 1'b0;
      o_timer_one_chan_zero_pin_free <= 1'b0;
      o_timer_one_chan_one_pin_free <= 1'b0;
      o_serial_zero_receive_pin_free <= 1'b0;
    end else begin
      o_conv_trigger <= next_conv;
      o_serial_zero_transmit_pin <= next_tx;
      o_serial_zero_receive <= next_rx;
      o_timer_zero_chan_one_in <= next_t0c1;
      o_timer_one_chan_zero_in <= next_t1c0;
      o_timer_one_chan_one_in <= next_t1c1;
      o_soft_sync_trigger <= sync_pulse;
      o_timer_zero_chan_zero_pin_free <= transmit_modulation_en;
      o_timer_zero_chan_one_pin_free <= receive_capture_en;
      o_timer_one_chan_zero_pin_free <= comparator_capture_route;
      o_timer_one_chan_one_pin_free <= counter_capture_route;
      o_serial_zero_receive_pin_free <= receive_filter_en;
    end
  end


  // checks
  tx_plain_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !transmit_modulation_en |=> o_serial_zero_transmit_pin == $past(i_serial_zero_transmit))
    else $error("transmit not passed straight through");
  tx_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    transmit_modulation_en && !i_timer_zero_chan_zero_out |=> !o_serial_zero_transmit_pin)
    else $error("transmit not gated by timer");
  rx_filter_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    receive_filter_en |=> o_serial_zero_receive == $past(comp_s))
    else $error("receive not fed from comparator");
  rx_capture_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    receive_capture_en |=> o_timer_zero_chan_one_in == o_serial_zero_receive)
    else $error("timer channel does not see receive input");
  cmp_capture_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    comparator_capture_route |=> o_timer_one_chan_zero_in == $past(comp_s))
    else $error("comparator not routed to timer one");
  cnt_capture_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    counter_capture_route |=> o_timer_one_chan_one_in == $past(i_counter_ovf))
    else $error("counter overflow not routed to timer one");
  sync_write_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    wr_pend && addr_q == signal_router_pkg::OPTIONS_ADDR
      && i_hwdata[signal_router_pkg::SYNC_BIT] |=> ##1 o_soft_sync_trigger ##1 !o_soft_sync_trigger)
    else $error("soft sync pulse missing or long");
  sync_read_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !o_hrdata[signal_router_pkg::SYNC_BIT])
    else $error("soft sync bit read as one");
  conv_direct_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    conv_trigger_select == signal_router_pkg::TRIG_PERIODIC |=>
      o_conv_trigger == $past(i_periodic_timer_flag))
    else $error("periodic trigger not selected");
  rx_free_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    receive_filter_en |=> o_serial_zero_receive_pin_free)
    else $error("receive pin not released");
  rx_direct_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !receive_capture_en |=> o_timer_zero_chan_one_in == $past(t0c1_pin_s))
    else $error("timer channel not fed from its own pin");
  conv_counter_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    conv_trigger_select == signal_router_pkg::TRIG_COUNTER_OVF |=>
      o_conv_trigger == $past(i_counter_ovf))
    else $error("counter overflow trigger not selected");
  conv_delayed_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    conv_trigger_select[1] |=> o_conv_trigger == $past(delay_fire))
    else $error("delayed timer trigger not selected");
endmodule

// file: sim/router_peripherals.sv
// behavioural model of the peripherals that feed the signal router
`timescale 1ns/1ps
module router_peripherals (
  // requests from the bench: held levels and one-cycle pulses
  input  wire logic [6:0] i_levels,
  input  wire logic [3:0] i_pulses,
  // levels towards the router
  output logic            o_cmp_out,
  output logic            o_t0c0_out,
  output logic            o_tx,
  output logic            o_rx_pin,
  output logic            o_t0c1_pin,
  output logic            o_t1c0_pin,
  output logic            o_t1c1_pin,
  // trigger pulses towards the router
  output logic            o_counter_ovf,
  output logic            o_periodic_flag,
  output logic            o_init_trigger,
  output logic            o_match_trigger
);
  // timer zero channel zero and the serial port never float, so gating is defined
  assign {o_t1c1_pin, o_t1c0_pin, o_t0c1_pin, o_rx_pin} = i_levels[6:3];
  assign {o_tx, o_t0c0_out, o_cmp_out} = i_levels[2:0];
  // pulses last exactly as long as the bench asks, one cycle in practice
  assign {o_match_trigger, o_init_trigger, o_periodic_flag, o_counter_ovf} = i_pulses;
endmodule

// file: sim/peripheral_signal_router_bench.sv
// self-checking bench for the peripheral signal router
`timescale 1ns/1ps
module peripheral_signal_router_bench;
  localparam logic [7:0] OPT = signal_router_pkg::OPTIONS_ADDR;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] rd;
  logic [31:0] o;
  logic [6:0]  levels;
  logic [6:0]  lv;
  logic [3:0]  pulses;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire  [10:0] per;
  wire  [9:0]  routes;
  wire         conv;
  wire         sync;
  int          errors;
  int          checked;
  int          cycles;
  int          n_conv;
  int          n_t1c1;
  int          n_sync;
  int          seed;

  // bus clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  router_peripherals model_u (
    .i_levels(levels), .i_pulses(pulses), .o_cmp_out(per[0]), .o_t0c0_out(per[1]),
    .o_tx(per[2]), .o_rx_pin(per[3]), .o_t0c1_pin(per[4]), .o_t1c0_pin(per[5]),
    .o_t1c1_pin(per[6]), .o_counter_ovf(per[7]), .o_periodic_flag(per[8]),
    .o_init_trigger(per[9]), .o_match_trigger(per[10]));

  peripheral_signal_router dut_u (
    .i_ref_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(signal_router_pkg::HSIZE_WORD), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_counter_ovf(per[7]), .i_periodic_timer_flag(per[8]), .i_timer_init_trigger(per[9]),
    .i_timer_match_trigger(per[10]), .i_comparator_zero_out(per[0]),
    .i_timer_zero_chan_zero_out(per[1]), .i_serial_zero_transmit(per[2]),
    .i_serial_zero_receive_pin(per[3]), .i_timer_zero_chan_one_pin(per[4]),
    .i_timer_one_chan_zero_pin(per[5]), .i_timer_one_chan_one_pin(per[6]),
    .o_conv_trigger(conv), .o_serial_zero_transmit_pin(routes[9]),
    .o_serial_zero_receive(routes[8]), .o_timer_zero_chan_one_in(routes[7]),
    .o_timer_one_chan_zero_in(routes[6]), .o_timer_one_chan_one_in(routes[5]),
    .o_soft_sync_trigger(sync), .o_timer_zero_chan_zero_pin_free(routes[4]),
    .o_timer_zero_chan_one_pin_free(routes[3]), .o_timer_one_chan_zero_pin_free(routes[2]),
    .o_timer_one_chan_one_pin_free(routes[1]), .o_serial_zero_receive_pin_free(routes[0]));

  // pulse widths are counted on the falling edge, away from register updates
  always @(negedge clk) begin
    n_conv = n_conv + int'(conv === 1'b1);
    n_t1c1 = n_t1c1 + int'(routes[5] === 1'b1);
    n_sync = n_sync + int'(sync === 1'b1);
  end

  // hang guard: the longest delay case is about 1100 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one single ahb-lite transfer; the wait ends only on hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= signal_router_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "response");
  endtask

  // routed levels and pin release flags expected for an option word
  function automatic logic [9:0] exp_routes(input logic [31:0] v, input logic [6:0] l);
    logic rx;
    rx = v[signal_router_pkg::RX_FILT_BIT] ? l[0] : l[3];
    exp_routes = {v[signal_router_pkg::TX_MOD_BIT] ? (l[2] & l[1]) : l[2], rx,
                  v[signal_router_pkg::RX_CAP_BIT] ? rx : l[4],
                  v[signal_router_pkg::CMP_CAP_BIT] ? l[0] : l[5],
                  v[signal_router_pkg::CNT_CAP_BIT] ? 1'b0 : l[6],
                  v[3], v[4], v[2], v[6], v[5]};
  endfunction

  task automatic pulse_case(input logic [31:0] v, input logic [3:0] p, input int ec,
                            input int et, input int es);
    n_conv = 0;
    n_t1c1 = 0;
    n_sync = 0;
    bus(1'b1, OPT, v);
    repeat (4) @(posedge clk);
    pulses <= p;
    @(posedge clk);
    pulses <= 4'h0;
    repeat (14) @(posedge clk);
    check(n_conv, ec, "converter pulses");
    check(n_t1c1, et, "capture pulses");
    check(n_sync, es, "sync pulses");
  endtask

  // latency from a sampled timer trigger to the converter pulse
  task automatic delay_case(input logic [1:0] s, input logic [7:0] d, input logic [2:0] b);
    int n;
    int exp;
    n = 0;
    // trigger edge, then d prescaled ticks, then the fire and output registers
    exp = (int'(d) << b) + 3;
    bus(1'b1, OPT, {13'h0, b, d, 6'h0, s});
    repeat (4) @(posedge clk);
    pulses <= (s == 2'h2) ? 4'b0100 : 4'b1000;
    @(posedge clk);
    pulses <= 4'h0;
    do begin
      @(negedge clk);
      n++;
    end while (conv !== 1'b1 && n < 1100);
    check(n, exp, "delay latency");
    @(negedge clk);
    check({31'h0, conv}, 32'h0, "pulse width");
  endtask

  initial begin
    seed = 32'h91f91a19;
    errors = 0;
    checked = 0;
    cycles = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    levels = 7'h00;
    pulses = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({29'h0, routes[9:8], conv}, 32'h6, "reset levels");
    bus(1'b0, OPT, 32'h0);
    check(rd, {13'h0, signal_router_pkg::OPT_RESET}, "options reset");
    bus(1'b0, signal_router_pkg::STATUS_ADDR, 32'h0);
    check(rd, 32'h0, "status idle");
    // unmapped place reads zero and ignores writes
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0, "unmapped read");
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, OPT, 32'h0);
    check(rd, 32'h0, "options after unmapped write");
    // random option words and levels, with all-clear and all-set first
    for (int i = 0; i < 24; i++) begin
      o = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : $random(seed);
      bus(1'b1, OPT, o);
      bus(1'b0, OPT, 32'h0);
      check(rd, o & 32'h0007FF7F, "options readback");
      lv = 7'($random(seed));
      levels <= lv;
      repeat (6) @(posedge clk);
      @(negedge clk);
      check({22'h0, routes}, {22'h0, exp_routes(o, lv)}, "routing");
    end
    @(posedge clk);
    levels <= 7'h00;
    repeat (6) @(posedge clk);
    pulse_case(32'h40, 4'b0001, 1, 1, 0);
    pulse_case(32'h00, 4'b0010, 0, 0, 0);
    pulse_case(32'h01, 4'b0010, 1, 0, 0);
    pulse_case(32'h01, 4'b0001, 0, 0, 0);
    pulse_case(32'h302, 4'b1000, 0, 0, 0);
    pulse_case(32'h303, 4'b0100, 0, 0, 0);
    pulse_case(32'h80, 4'b0000, 0, 0, 1);
    pulse_case(32'h00, 4'b0000, 0, 0, 0);
    delay_case(2'h2, 8'h00, 3'h0);
    delay_case(2'h3, 8'hFF, 3'h0);
    delay_case(2'h2, 8'($random(seed)), 3'h1);
    delay_case(2'h3, 8'($random(seed)), 3'h2);
    delay_case(2'h2, 8'h07, 3'h3);
    // a long delay leaves the counter busy when status is read
    bus(1'b1, OPT, {13'h0, 3'h7, 8'hFF, 6'h0, 2'h2});
    @(posedge clk);
    pulses <= 4'b0100;
    @(posedge clk);
    pulses <= 4'h0;
    bus(1'b0, signal_router_pkg::STATUS_ADDR, 32'h0);
    check(rd, 32'h1, "status busy");
    stop_test();
  end
endmodule
